// File: common/adc_regs_map.svh
`ifndef ADC_REGS_MAP_SVH
`define ADC_REGS_MAP_SVH

// ****************************************
// bus geometry
// ****************************************
`define ADDR_W 3
`define DATA_W 16
`define RES_W_DEF 10

// ****************************************
// register offsets (word index on the plain port)
// ****************************************
`define OFS_RESULT0 3'h0
`define OFS_RESULT3 3'h3
`define OFS_CSR 3'h4

// ****************************************
// control/status field positions
// ****************************************
`define BIT_FLAG 15
`define BIT_IE 14
`define BIT_START 13
`define BIT_DMASEL 12
`define RSVD_HI_MSB 11
`define RSVD_HI_LSB 8
`define CKS_MSB 7
`define CKS_LSB 6
`define MODE_MSB 5
`define MODE_LSB 4
`define CH_MSB 1
`define CH_LSB 0

// ****************************************
// reset values and encodings
// ****************************************
`define RESULT_RESET 10'h000
`define CKS_RESET 2'h1
`define CH_RESET 2'h0
`define CHAN_FIRST 2'h0
`define CHAN_STEP 2'h1
`define RSVD_HI_VAL 4'h0
`define RSVD_LO_VAL 2'h0
`define MODE_SINGLE_CODE 2'h0
`define MODE_BAD_CODE 2'h1
`define MODE_MULTI_CODE 2'h2
`define MODE_SCAN_CODE 2'h3
`define ST_IDLE_CODE 2'h0
`define ST_ISSUE_CODE 2'h1
`define ST_WAIT_CODE 2'h3

`endif

// File: common/adc_pkg.sv
`include "adc_regs_map.svh"
package adc_pkg;

   typedef enum logic [1:0]
   {
      MODE_SINGLE = `MODE_SINGLE_CODE,
      MODE_BAD = `MODE_BAD_CODE,
      MODE_MULTI = `MODE_MULTI_CODE,
      MODE_SCAN = `MODE_SCAN_CODE
   } mode_e;

   // gray along idle -> issue -> wait -> issue
   typedef enum logic [1:0]
   {
      SEQ_IDLE = `ST_IDLE_CODE,
      SEQ_ISSUE = `ST_ISSUE_CODE,
      SEQ_WAIT = `ST_WAIT_CODE
   } seq_state_e;

endpackage

// File: rtl/adc_result_and_control_regs.sv
// Operation
// - four 16-bit result registers, one per input, read-only to software.
// - a finished conversion writes its 10-bit result into bits 15..6.
// - bits 5..0 of every result register always read zero.
// - all result registers start at zero.
// - inputs 0..3 store into result registers 0..3 respectively.
// - one 16-bit read/write control/status register selects mode and controls.
// - end flag sets after a single conversion or a full multi/scan pass.
// - flag clears by read-while-1 then write 0; writing 1 is ignored.
// - a DMA read of a result register clears the end flag while the select bit is 1.
// - interrupt request comes from the flag only while interrupt enable is 1.
// - writing 1 to start begins conversion; start reads 1 while converting.
// - writing 0 to start stops conversion.
// - single mode clears start when the channel conversion completes.
// - multi mode clears start after one pass over all selected channels.
// - scan mode repeats until software, reset or standby clears start.
// - select bit routes the end event to interrupt (0) or DMA (1).
// - control bits 11..8 read zero; software writes only zero there.
// - flag, enable, start and select bits reset to zero.
// - mode field: 00 single, 10 multi, 11 scan, 01 prohibited.
// - channel field picks one input in single, inputs 0..N otherwise.
// - multi mode converts from the lowest channel upward, storing each.
`timescale 1ns/100ps
`include "adc_regs_map.svh"
module adc_result_and_control_regs
#(
   parameter int RES_W = `RES_W_DEF
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic standby,
   // register port
   input wire logic [`ADDR_W-1:0] regAddr,
   input wire logic [`DATA_W-1:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic regRdDma,
   output logic [`DATA_W-1:0] regRdData,
   // analog core
   output logic convStart,
   output logic [1:0] convChannel,
   output logic [1:0] convClockSel,
   input wire logic convDone,
   input wire logic [RES_W-1:0] convResult,
   // end-of-conversion requests
   output logic irqReq,
   output logic dmaReq
);

   // ****************************************
   // elaboration check
   // ****************************************
   generate
      if (RES_W < 1 || RES_W > `DATA_W)
      begin : gBadWidth
         $error("result width must lie between 1 and the data width");
      end
   endgenerate

   // ****************************************
   // state
   // ****************************************
   logic [RES_W-1:0] resultReg [4];
   logic flagReg;
   logic flagNext;
   logic armReg;
   logic armNext;
   logic ieReg;
   logic startReg;
   logic startNext;
   logic dmaSelReg;
   logic [1:0] cksReg;
   adc_pkg::mode_e modeReg;
   logic [1:0] chReg;
   logic [1:0] chanReg;
   logic [1:0] chanNext;
   adc_pkg::seq_state_e stateReg;
   adc_pkg::seq_state_e stateNext;
   logic [`DATA_W-1:0] rdDataReg;
   logic [`DATA_W-1:0] rdDataNext;

   // ****************************************
   // decode
   // ****************************************
   wire logic wrCsr = clkEn & regWrEn & (regAddr == `OFS_CSR);
   wire logic rdCsr = clkEn & regRdEn & (regAddr == `OFS_CSR);
   wire logic rdRes = clkEn & regRdEn & (regAddr <= `OFS_RESULT3);
   wire logic wStart = regWrData[`BIT_START];
   wire adc_pkg::mode_e wMode = adc_pkg::mode_e'(regWrData[`MODE_MSB:`MODE_LSB]);
   wire logic [1:0] wCh = regWrData[`CH_MSB:`CH_LSB];
   // a prohibited mode code behaves as single mode
   wire logic wSingle = (wMode == adc_pkg::MODE_SINGLE) || (wMode == adc_pkg::MODE_BAD);
   wire logic isScan = (modeReg == adc_pkg::MODE_SCAN);

   // start is honoured only from rest; a second 1 while running does not restart the sequence
   wire logic go = wrCsr & wStart & ~startReg & ~standby;
   // standby clears start as a reset would
   wire logic stopReq = (wrCsr & ~wStart) | (clkEn & standby);
   // a done strobe is counted only while a conversion is outstanding
   wire logic doneTake = clkEn & convDone & (stateReg == adc_pkg::SEQ_WAIT) & ~stopReq;
   // single mode starts at the field's channel, so the same compare ends both
   wire logic lastChan = (chanReg == chReg);
   wire logic lastDone = doneTake & lastChan;

   wire logic flagClrSw = wrCsr & ~regWrData[`BIT_FLAG] & armReg;
   wire logic flagClrDma = rdRes & regRdDma & dmaSelReg;

   // ****************************************
   // read mux
   // ****************************************
   wire logic [`DATA_W-1:0] csrValue =
   {
      flagReg,
      ieReg,
      startReg,
      dmaSelReg,
      `RSVD_HI_VAL,
      cksReg,
      modeReg,
      `RSVD_LO_VAL,
      chReg
   };
   // result sits left-aligned so the unused low bits read zero
   wire logic [`DATA_W-1:0] resValue =
      `DATA_W'(resultReg[regAddr[1:0]]) << (`DATA_W - RES_W);

   always_comb
   begin
      rdDataNext = '0;
      if (rdCsr)
      begin
         rdDataNext = csrValue;
      end
      else if (rdRes)
      begin
         rdDataNext = resValue;
      end
   end

   // ****************************************
   // flag and sequencer next state
   // ****************************************
   always_comb
   begin
      // setting wins over a clear in the same cycle
      flagNext = lastDone | (flagReg & ~(flagClrSw | flagClrDma));
      armNext = (rdCsr & flagReg) | (armReg & flagReg & ~wrCsr);

      startNext = startReg;
      if (stopReq)
      begin
         startNext = 1'b0;
      end
      else if (go)
      begin
         startNext = 1'b1;
      end
      else if (lastDone && !isScan)
      begin
         startNext = 1'b0;
      end

      chanNext = chanReg;
      if (go)
      begin
         chanNext = wSingle ? wCh : `CHAN_FIRST;
      end
      else if (doneTake && !lastChan)
      begin
         chanNext = chanReg + `CHAN_STEP;
      end
      else if (lastDone && isScan)
      begin
         chanNext = `CHAN_FIRST;
      end

      stateNext = stateReg;
      case (stateReg)
         adc_pkg::SEQ_IDLE:
         begin
            if (go)
            begin
               stateNext = adc_pkg::SEQ_ISSUE;
            end
         end
         adc_pkg::SEQ_ISSUE:
         begin
            if (stopReq)
            begin
               stateNext = adc_pkg::SEQ_IDLE;
            end
            else if (clkEn)
            begin
               stateNext = adc_pkg::SEQ_WAIT;
            end
         end
         adc_pkg::SEQ_WAIT:
         begin
            if (stopReq)
            begin
               stateNext = adc_pkg::SEQ_IDLE;
            end
            else if (lastDone && !isScan)
            begin
               stateNext = adc_pkg::SEQ_IDLE;
            end
            else if (doneTake)
            begin
               stateNext = adc_pkg::SEQ_ISSUE;
            end
         end
         default:
         begin
            stateNext = adc_pkg::SEQ_IDLE;
         end
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         flagReg <= 1'b0;
         armReg <= 1'b0;
         ieReg <= 1'b0;
         startReg <= 1'b0;
         dmaSelReg <= 1'b0;
         cksReg <= `CKS_RESET;
         modeReg <= adc_pkg::MODE_SINGLE;
         chReg <= `CH_RESET;
      end
      else if (clkEn)
      begin
         flagReg <= flagNext;
         armReg <= armNext;
         startReg <= startNext;
         if (wrCsr)
         begin
            ieReg <= regWrData[`BIT_IE];
            dmaSelReg <= regWrData[`BIT_DMASEL];
            cksReg <= regWrData[`CKS_MSB:`CKS_LSB];
            modeReg <= wMode;
            chReg <= wCh;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 4; i++)
         begin
            resultReg[i] <= RES_W'(`RESULT_RESET);
         end
      end
      else if (doneTake)
      begin
         resultReg[chanReg] <= convResult;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         stateReg <= adc_pkg::SEQ_IDLE;
         chanReg <= `CHAN_FIRST;
         rdDataReg <= '0;
      end
      else if (clkEn)
      begin
         stateReg <= stateNext;
         chanReg <= chanNext;
         rdDataReg <= rdDataNext;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign regRdData = rdDataReg;
   assign convStart = clkEn & (stateReg == adc_pkg::SEQ_ISSUE);
   assign convChannel = chanReg;
   assign convClockSel = cksReg;
   // the enable bit never opens the interrupt while DMA owns the event
   assign irqReq = flagReg & ieReg & ~dmaSelReg;
   assign dmaReq = flagReg & dmaSelReg;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   AST_STORE: assert property (doneTake |=> resultReg[$past(chanReg)] == $past(convResult))
      else $error("result not stored in converted channel");
   AST_RES_LOW_ZERO: assert property (rdRes |=> (regRdData << RES_W) == '0)
      else $error("result low bits not zero");
   AST_CSR_RSVD: assert property (rdCsr |=> regRdData[`RSVD_HI_MSB:`RSVD_HI_LSB] == '0)
      else $error("reserved control bits not zero");
   AST_FLAG_SET: assert property (lastDone |=> flagReg)
      else $error("end flag not set after pass");
   AST_W1_IGNORED: assert property (wrCsr && regWrData[`BIT_FLAG] && !flagReg
      && !lastDone |=> !flagReg)
      else $error("writing 1 set the end flag");
   AST_SW_CLEAR: assert property (rdCsr && flagReg ##1 !wrCsr ##1 wrCsr
      && !regWrData[`BIT_FLAG] && !lastDone |=> !flagReg)
      else $error("read then write 0 did not clear flag");
   AST_DMA_CLEAR: assert property (flagClrDma && !lastDone |=> !flagReg)
      else $error("dma read did not clear flag");
   AST_IRQ_GATE: assert property (lastDone |=> irqReq == (ieReg && !dmaSelReg))
      else $error("interrupt request not gated");
   AST_DMA_REQ: assert property (lastDone |=> dmaReq == dmaSelReg)
      else $error("dma request not raised after pass");
   AST_GO: assert property (go |=> startReg && stateReg == adc_pkg::SEQ_ISSUE)
      else $error("start write did not begin conversion");
   AST_STOP: assert property (wrCsr && !wStart
      |=> !startReg && stateReg == adc_pkg::SEQ_IDLE)
      else $error("writing 0 to start did not stop");
   AST_SINGLE_END: assert property (lastDone && modeReg == adc_pkg::MODE_SINGLE
      |=> !startReg && stateReg == adc_pkg::SEQ_IDLE)
      else $error("single mode did not end");
   AST_MULTI_END: assert property (lastDone && modeReg == adc_pkg::MODE_MULTI
      |=> !startReg && stateReg == adc_pkg::SEQ_IDLE)
      else $error("multi mode did not end after pass");
   AST_SCAN_WRAP: assert property (lastDone && isScan
      |=> startReg && chanReg == `CHAN_FIRST && stateReg == adc_pkg::SEQ_ISSUE)
      else $error("scan mode did not restart");
   AST_MULTI_STEP: assert property (doneTake && !lastChan
      |=> chanReg == $past(chanReg) + `CHAN_STEP)
      else $error("multi mode did not advance channel");
   AST_MULTI_FIRST: assert property (go && !wSingle |=> convChannel == `CHAN_FIRST)
      else $error("multi or scan mode did not begin at the lowest channel");
   AST_SINGLE_CH: assert property (convStart && !isScan
      && modeReg != adc_pkg::MODE_MULTI |-> convChannel == chReg)
      else $error("single mode converts the wrong channel");
   AST_CHAN_HOLD: assert property (stateReg == adc_pkg::SEQ_WAIT && !doneTake
      && !stopReq |=> $stable(convChannel))
      else $error("channel moved during a conversion");
   AST_ISSUE_ONE: assert property (convStart |=> !convStart)
      else $error("start strobe longer than one cycle");
   AST_START_HOLD: assert property (startReg && !stopReq && !lastDone |=> startReg)
      else $error("start bit dropped during conversion");
   AST_STANDBY_STOP: assert property (clkEn && standby
      |=> !startReg && stateReg == adc_pkg::SEQ_IDLE)
      else $error("standby did not stop conversion");
   AST_FLAG_HOLD: assert property (flagReg && !flagClrSw && !flagClrDma |=> flagReg)
      else $error("end flag dropped without a clear");
   AST_RES_READ: assert property (rdRes
      |=> regRdData[`DATA_W-1 -: RES_W] == $past(resultReg[regAddr[1:0]]))
      else $error("result read does not match the stored value");
   AST_RES_RO: assert property (regWrEn && !doneTake
      |=> resultReg[$past(regAddr[1:0])] == $past(resultReg[regAddr[1:0]]))
      else $error("a register write changed a result");
   // a frozen cycle must not lose a pending start or flag
   AST_FREEZE: assert property (!clkEn
      |=> $stable(stateReg) && $stable(startReg) && $stable(flagReg) && $stable(chReg))
      else $error("state moved while the clock enable was low");

   // ****************************************
   // cover points
   // ****************************************
   CV_SINGLE: cover property (lastDone && modeReg == adc_pkg::MODE_SINGLE);
   CV_MULTI: cover property (lastDone && modeReg == adc_pkg::MODE_MULTI && chReg == 2'h3);
   CV_SCAN: cover property (lastDone && isScan ##[1:100] lastDone);
   CV_DMA: cover property (flagClrDma && flagReg);
   CV_STANDBY: cover property (clkEn && standby && startReg);

endmodule

// File: tb/adc_core_model.sv
`timescale 1ns/100ps
// ****************************************
// analog core stand-in
// ****************************************
module adc_core_model
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // requests from the sequencer and the bench
   input wire logic convStart,
   input wire logic abort,
   input wire logic [3:0] waitCycles,
   input wire logic [9:0] resultIn,
   // answer
   output logic convDone,
   output logic [9:0] convResult
);
   logic busy;
   logic [3:0] count;

   // outside a done pulse the result toggles, so a stale value is never usable
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         busy <= 1'b0;
         count <= 4'h0;
         convDone <= 1'b0;
         convResult <= 10'h000;
      end
      else
      begin
         convDone <= 1'b0;
         convResult <= ~convResult;
         if (abort)
         begin
            // a stopped conversion never answers late
            busy <= 1'b0;
         end
         else if (convStart)
         begin
            busy <= 1'b1;
            count <= waitCycles;
         end
         else if (busy && count == 4'h0)
         begin
            busy <= 1'b0;
            convDone <= 1'b1;
            convResult <= resultIn;
         end
         else if (busy)
         begin
            count <= count - 4'h1;
         end
      end
   end
endmodule

// File: tb/adc_result_and_control_regs_test.sv
`timescale 1ns/100ps
`include "adc_regs_map.svh"
module adc_result_and_control_regs_test;
   logic sys_clk = 1'b0;
   logic rst, standby, regWrEn, regRdEn, regRdDma, abort, clkEn;
   logic convStart, convDone, irqReq, dmaReq;
   logic [2:0] regAddr;
   logic [1:0] convChannel, convClockSel;
   logic [15:0] regWrData, regRdData, q, d;
   logic [9:0] convResult, resultIn;
   logic [3:0] waitCycles;
   logic [15:0] expRes [4];
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   int expChan, lastN, curMode;
   logic [1:0] modes [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h3, 2'h1};
   logic [1:0] chans [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h1, 2'h2, 2'h2};

   always #5 sys_clk = ~sys_clk;

   adc_result_and_control_regs #(.RES_W(10)) dut
   (
      .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .standby(standby),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdDma(regRdDma), .regRdData(regRdData), .convStart(convStart),
      .convChannel(convChannel), .convClockSel(convClockSel), .convDone(convDone),
      .convResult(convResult), .irqReq(irqReq), .dmaReq(dmaReq)
   );

   adc_core_model core
   (
      .sys_clk(sys_clk), .rst(rst), .convStart(convStart), .abort(abort),
      .waitCycles(waitCycles), .resultIn(resultIn), .convDone(convDone),
      .convResult(convResult)
   );

   // ****************************************
   // checking and bus tasks
   // ****************************************
   task automatic results();
      if (errors == 0 && check_count > 0)
      begin
         $display("Test passed");
      end
      else
      begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // the trailing edge keeps two writes from touching the strobe in one step
   task automatic wr(input logic [2:0] a, input logic [15:0] v);
      regAddr <= a;
      regWrData <= v;
      regWrEn <= 1'b1;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [2:0] a, input logic dma, output logic [15:0] v);
      regAddr <= a;
      regRdDma <= dma;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      regRdDma <= 1'b0;
      @(posedge sys_clk);
      v = regRdData;
   endtask

   task automatic waitCsr(input int b, input logic v);
      int n;
      n = 0;
      do
      begin
         rd(`OFS_CSR, 1'b0, q);
         n++;
      end
      while (q[b] !== v && n < 200);
      chk({15'h0, q[b]}, {15'h0, v});
   endtask

   // ****************************************
   // one conversion run and its checks
   // ****************************************
   task automatic runOp(input logic [1:0] m, input logic [1:0] ch, input logic ie,
      input logic sel);
      d = {1'b0, ie, 1'b1, sel, 4'h0, 2'h1, m, 2'h0, ch};
      // the prohibited code 01 runs as single mode
      curMode = int'(m[1]);
      lastN = ch;
      expChan = m[1] ? 0 : int'(ch);
      waitCycles <= 4'(3 + $urandom % 8);
      wr(`OFS_CSR, d);
      rd(`OFS_CSR, 1'b0, q);
      chk(q & 16'h2000, 16'h2000);
      d[13] = 1'b0;
      if (m == 2'h3)
      begin
         waitCsr(15, 1'b1);
         chk(q & 16'h2000, 16'h2000);
         abort <= 1'b1;
         wr(`OFS_CSR, d);
         abort <= 1'b0;
         rd(`OFS_CSR, 1'b0, q);
         chk(q, d);
      end
      else
      begin
         waitCsr(13, 1'b0);
         chk(q, d | 16'h8000);
         chk({15'h0, irqReq}, {15'h0, ie & ~sel});
         chk({15'h0, dmaReq}, {15'h0, sel});
         if (sel)
         begin
            rd({1'b0, ch}, 1'b1, q);
            chk(q, expRes[ch]);
            chk({15'h0, dmaReq}, 16'h0000);
         end
         else
         begin
            wr(`OFS_CSR, d | 16'h8000);
            rd(`OFS_CSR, 1'b0, q);
            chk(q, d | 16'h8000);
            wr(`OFS_CSR, d);
            rd(`OFS_CSR, 1'b0, q);
            chk(q, d);
         end
      end
      for (int i = 0; i < 4; i++)
      begin
         rd(3'(i), 1'b0, q);
         chk(q, expRes[i]);
      end
   endtask

   // ****************************************
   // reference model and watchdog
   // ****************************************
   always @(posedge sys_clk)
   begin
      resultIn <= 10'($urandom);
      cycles++;
      if (cycles == 30000)
      begin
         errors++;
         results();
      end
      if (convStart === 1'b1)
      begin
         chk({14'h0, convChannel}, 16'(expChan));
      end
      if (convDone === 1'b1 && !abort)
      begin
         expRes[expChan] = {convResult, 6'h00};
         if (curMode != 0)
         begin
            expChan = (expChan == lastN) ? 0 : expChan + 1;
         end
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      rst = 1'b1;
      standby = 1'b0;
      clkEn = 1'b1;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regRdDma = 1'b0;
      abort = 1'b0;
      regAddr = 3'h0;
      regWrData = 16'h0000;
      waitCycles = 4'h3;
      resultIn = 10'h000;
      expRes = '{default: 16'h0000};
      void'($urandom(46561));
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         rd(3'(i), 1'b0, q);
         chk(q, (i == 4) ? 16'h0040 : 16'h0000);
      end
      chk({14'h0, convClockSel}, 16'h0001);
      // a write while the clock enable is low must change nothing
      clkEn <= 1'b0;
      wr(`OFS_CSR, 16'h2081);
      clkEn <= 1'b1;
      rd(`OFS_CSR, 1'b0, q);
      chk(q, 16'h0040);
      chk({14'h0, convClockSel}, 16'h0001);
      wr(3'h0, 16'hFFFF);
      wr(3'h7, 16'hFFFF);
      wr(`OFS_CSR, 16'h8F8C);
      rd(`OFS_CSR, 1'b0, q);
      chk(q, 16'h0080);
      chk({14'h0, convClockSel}, 16'h0002);
      rd(3'h0, 1'b0, q);
      chk(q, 16'h0000);
      for (int i = 0; i < 8; i++)
      begin
         runOp(modes[i], chans[i], 1'(i), 1'b0);
      end
      runOp(2'h0, 2'h2, 1'b1, 1'b1);
      runOp(2'h2, 2'h3, 1'b1, 1'b1);
      // standby in mid-conversion behaves like a stop
      waitCycles <= 4'hF;
      curMode = 0;
      expChan = 1;
      wr(`OFS_CSR, 16'h2041);
      standby <= 1'b1;
      abort <= 1'b1;
      @(posedge sys_clk);
      standby <= 1'b0;
      abort <= 1'b0;
      rd(`OFS_CSR, 1'b0, q);
      chk(q, 16'h0041);
      results();
   end
endmodule
